// ### tadc_chk.sv
// Assertions on the conversion-control block, from its ports alone.
// Assumes one pclk domain and the asynchronous active-low presetn.
module tadc_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // Conversion side
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic [3:0] input_channel_code,
    input wire logic single_diff_select,
    input wire logic [3:0] plate_sw
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr1, sds_reg, act_reg;
    logic [1:0] ivl_reg, md_reg, idle_reg;
    logic [3:0] ch_reg, sw_exp;
    // Control word write as seen on the bus
    assign wr1 = psel && penable && pwrite && paddr == 12'h000;
    // Plate pattern the coded channel needs
    assign sw_exp = input_channel_code == 4'h0 ? 4'h3 : input_channel_code == 4'h1 ? 4'hC :
        input_channel_code == 4'h2 || input_channel_code == 4'hA ? 4'h6 : 4'h0;
    // Shadows of written fields; idle_reg saturates so a late open switch is still caught
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sds_reg, act_reg, ivl_reg, md_reg, idle_reg, ch_reg} <= 12'h000;
        end else begin
            if (wr1) begin
                {sds_reg, ch_reg, md_reg} <= {pwdata[11:7], pwdata[1:0]};
            end
            if (psel && penable && pwrite && paddr == 12'h004) begin
                ivl_reg <= pwdata[1:0];
            end
            act_reg <= conv_start || (act_reg && !conv_done);
            idle_reg <= (act_reg || conv_start) ? 2'h0 : idle_reg + {1'h0, idle_reg != 2'h3};
        end
    end
    a_reset_quiet: assert property (disable iff (1'h0)
        !presetn |-> !conv_start && plate_sw == 4'h0) else $error("output active in reset");
    a_idle_none: assert property (wr1 && pwdata[1:0] == 2'h0 |=> !conv_start [*8])
        else $error("start in idle mode");
    a_single_go: assert property (wr1 && pwdata[1:0] == 2'h1 && pwdata[10:7] <= 4'hA
        |-> ##[1:3] (conv_start && input_channel_code == ch_reg)) else $error("no single start");
    a_once_stop: assert property (conv_done && ivl_reg == 2'h0 && md_reg == 2'h1
        |=> !conv_start [*8]) else $error("single repeated without interval");
    a_sds_follow: assert property (conv_start |-> single_diff_select == sds_reg)
        else $error("wrong conversion method");
    a_code_valid: assert property (conv_start |-> input_channel_code <= 4'hA)
        else $error("invalid channel converted");
    a_plate_map: assert property (conv_start |-> plate_sw == sw_exp)
        else $error("wrong plate pattern");
    a_plate_open: assert property (idle_reg[1] && !conv_start |-> plate_sw == 4'h0)
        else $error("plates closed while idle");
    a_plate_hold: assert property (act_reg && !conv_start |-> $stable(plate_sw))
        else $error("plates moved mid conversion");
    c_single: cover property (conv_start && md_reg == 2'h1);
    c_slave: cover property (conv_start && md_reg == 2'h2);
    c_master: cover property (conv_start && md_reg == 2'h3);
endmodule

// ### tadc_clkdiv.sv
// Divider giving a one-cycle enable pulse every DIV pclk cycles.
// Assumes a free-running pclk and active-low asynchronous reset.
module tadc_clkdiv #(
    parameter int DIV = 20
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Enable output
    output logic tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } tadc_div_t;
    tadc_div_t s_reg, s_next;

    // Count down and pulse at wrap
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.cnt == 16'h0000) begin
            s_next.cnt = 16'(DIV - 1);
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt - 16'h0001;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;
endmodule

// ### tadc_core_model.sv
// Behavioural analog core facing the conversion-control block.
// Assumes the same pclk and reset; lat sets the answer delay in cycles.
module tadc_core_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Conversion handshake
    input wire logic conv_start,
    input wire logic [7:0] lat,
    output logic conv_done
);
    logic run;
    logic [7:0] cnt;
    // Count down from each start, then pulse done once; lat lets prompt and slow cores be tried
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {run, cnt, conv_done} <= 10'h000;
        end else begin
            conv_done <= run && cnt == 8'h00;
            if (conv_start) begin
                run <= 1'h1;
                cnt <= lat;
            end else if (run) begin
                run <= cnt != 8'h00;
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule

// ### tadc_ctrl.sv
// Conversion-control logic of a touch-screen ADC: mode decode, sequencer,
// repeat timer, plate switch drive. APB slave for its registers.
// Assumes the analog core reports conversion end with conv_done, and
// the touch detector gives a synchronous touched level.
module tadc_ctrl (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog core and touch detector
    input wire logic touched,
    input wire logic conv_done,
    output logic conv_start,
    output logic [3:0] input_channel_code,
    output logic single_diff_select,
    output logic [3:0] plate_sw
);
    typedef enum logic [1:0] {ST_IDLE, ST_PICK, ST_CONV, ST_WAIT} tadc_st_t;

    typedef struct packed {
        logic [11:0] ctrl1;
        logic [11:0] ctrl2;
        logic [11:0] seq0;
        logic [11:0] seq1;
        tadc_st_t st;
        logic [3:0] ch;
        logic [14:0] rep_cnt;
        logic prev_touch;
        logic [31:0] prdata;
        logic pslverr;
        logic conv_start;
        logic [3:0] chan_out;
        logic sds_out;
        logic [3:0] sw;
        logic busy;
    } tadc_state_t;

    tadc_state_t s_reg, s_next;
    logic tick;
    logic wr_en;
    logic rd_en;
    logic [1:0] mode;
    logic [11:0] seq_sel;
    logic [3:0] nxt_ch;
    logic found;
    logic [14:0] rep_len;
    logic [3:0] sw_pat;

    // Conversion clock enable
    tadc_clkdiv #(.DIV(tadc_pkg::CONV_DIV)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    // APB strobes; reads decode in the setup phase so data stands at the access edge
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign mode = s_reg.ctrl1[1:0];
    assign seq_sel = (mode == tadc_pkg::MODE_MASTER) ? s_reg.seq1 : s_reg.seq0;

    always_comb begin
        case (s_reg.ctrl2[1:0])
            2'h1: rep_len = 15'(tadc_pkg::REP_1 - 1);
            2'h2: rep_len = 15'(tadc_pkg::REP_2 - 1);
            2'h3: rep_len = 15'(tadc_pkg::REP_3 - 1);
            default: rep_len = 15'h0000;
        endcase
    end

    // next enabled channel at or above s_reg.ch
    always_comb begin
        nxt_ch = 4'h0;
        found = 1'b0;
        for (int i = 10; i >= 0; i--) begin
            if (seq_sel[11 - i] && (4'(i) >= s_reg.ch)) begin
                nxt_ch = 4'(i);
                found = 1'b1;
            end
        end
    end

    always_comb begin
        case (s_reg.ch)
            tadc_pkg::CH_YPOS: sw_pat = tadc_pkg::SW_Y_ON;
            tadc_pkg::CH_XPOS: sw_pat = tadc_pkg::SW_X_ON;
            tadc_pkg::CH_Z2: sw_pat = tadc_pkg::SW_PRESS;
            tadc_pkg::CH_Z1: sw_pat = tadc_pkg::SW_PRESS;
            default: sw_pat = tadc_pkg::SW_OFF;
        endcase
    end

    // Sequencer, register file and outputs
    always_comb begin
        s_next = s_reg;
        s_next.conv_start = 1'b0;
        s_next.prev_touch = touched;
        // Error flag decoded in setup, held through the access phase
        s_next.pslverr = s_reg.pslverr & psel & penable;
        if (psel && !penable && pwrite) begin
            case (paddr)
                tadc_pkg::ADDR_CTRL1, tadc_pkg::ADDR_CTRL2,
                tadc_pkg::ADDR_SEQ0, tadc_pkg::ADDR_SEQ1: s_next.pslverr = 1'b0;
                default: s_next.pslverr = 1'b1;
            endcase
        end
        // Register writes; main control write restarts the sequencer
        if (wr_en) begin
            case (paddr)
                tadc_pkg::ADDR_CTRL1: begin
                    s_next.ctrl1 = pwdata[11:0];
                    s_next.st = ST_IDLE;
                end
                tadc_pkg::ADDR_CTRL2: s_next.ctrl2 = pwdata[11:0];
                tadc_pkg::ADDR_SEQ0: s_next.seq0 = pwdata[11:0];
                tadc_pkg::ADDR_SEQ1: s_next.seq1 = pwdata[11:0];
                default: ;
            endcase
        end
        if (rd_en) begin
            case (paddr)
                tadc_pkg::ADDR_CTRL1: s_next.prdata = {20'h00000, s_reg.ctrl1};
                tadc_pkg::ADDR_CTRL2: s_next.prdata = {20'h00000, s_reg.ctrl2};
                tadc_pkg::ADDR_SEQ0: s_next.prdata = {20'h00000, s_reg.seq0};
                tadc_pkg::ADDR_SEQ1: s_next.prdata = {20'h00000, s_reg.seq1};
                tadc_pkg::ADDR_STATUS: s_next.prdata = {26'h0000000, s_reg.busy,
                                                        touched, s_reg.ch};
                default: begin
                    s_next.prdata = 32'h00000000;
                    s_next.pslverr = 1'b1;
                end
            endcase
        end
        if (!(wr_en && paddr == tadc_pkg::ADDR_CTRL1)) begin
            case (s_reg.st)
                ST_IDLE: begin
                    s_next.busy = 1'b0;
                    s_next.ch = 4'h0;
                    case (mode)
                        tadc_pkg::MODE_SINGLE: begin
                            s_next.ch = s_reg.ctrl1[tadc_pkg::CH_LSB +: 4];
                            s_next.st = ST_PICK;
                        end
                        tadc_pkg::MODE_SLAVE_SEQ: s_next.st = ST_PICK;
                        // wait for touch; a rising edge of touched starts at once
                        tadc_pkg::MODE_MASTER: begin
                            if (touched && !s_reg.prev_touch) begin
                                s_next.st = ST_PICK;
                            end
                        end
                        default: s_next.st = ST_IDLE;
                    endcase
                end
                ST_PICK: begin
                    if (mode == tadc_pkg::MODE_SINGLE) begin
                        if (s_reg.ch <= tadc_pkg::CH_LAST) begin
                            s_next.st = ST_CONV;
                            s_next.conv_start = 1'b1;
                            s_next.busy = 1'b1;
                        end else begin
                            s_next.st = ST_WAIT;
                        end
                    end else if (found) begin
                        s_next.ch = nxt_ch;
                        s_next.st = ST_CONV;
                        s_next.conv_start = 1'b1;
                        s_next.busy = 1'b1;
                    end else begin
                        s_next.st = ST_WAIT;
                    end
                    s_next.rep_cnt = rep_len;
                end
                ST_CONV: begin
                    if (conv_done) begin
                        s_next.busy = 1'b0;
                        if (mode == tadc_pkg::MODE_SINGLE || s_reg.ch == tadc_pkg::CH_LAST)
                        begin
                            s_next.st = ST_WAIT;
                        end else begin
                            s_next.ch = s_reg.ch + 4'h1;
                            s_next.st = ST_PICK;
                        end
                    end
                end
                ST_WAIT: begin
                    s_next.busy = 1'b0;
                    if (mode == tadc_pkg::MODE_MASTER) begin
                        if (!touched) begin
                            s_next.st = ST_IDLE;
                        end else if (s_reg.ctrl2[1:0] != 2'h0 && tick) begin
                            if (s_reg.rep_cnt == 15'h0000) begin
                                s_next.ch = 4'h0;
                                s_next.st = ST_PICK;
                            end else begin
                                s_next.rep_cnt = s_reg.rep_cnt - 15'h0001;
                            end
                        end
                    // zero interval returns mode to idle
                    end else if (s_reg.ctrl2[1:0] == 2'h0) begin
                        s_next.ctrl1[1:0] = tadc_pkg::MODE_IDLE;
                        s_next.st = ST_IDLE;
                    end else if (tick) begin
                        if (s_reg.rep_cnt == 15'h0000) begin
                            s_next.ch = (mode == tadc_pkg::MODE_SINGLE) ?
                                s_reg.ctrl1[tadc_pkg::CH_LSB +: 4] : 4'h0;
                            s_next.st = ST_PICK;
                        end else begin
                            s_next.rep_cnt = s_reg.rep_cnt - 15'h0001;
                        end
                    end
                end
                default: s_next.st = ST_IDLE;
            endcase
        end
        s_next.sw = (s_next.st == ST_CONV) ? sw_pat : tadc_pkg::SW_OFF;
        if (s_next.st == ST_CONV && s_reg.st != ST_CONV) begin
            case (s_next.ch)
                tadc_pkg::CH_YPOS: s_next.sw = tadc_pkg::SW_Y_ON;
                tadc_pkg::CH_XPOS: s_next.sw = tadc_pkg::SW_X_ON;
                tadc_pkg::CH_Z2: s_next.sw = tadc_pkg::SW_PRESS;
                tadc_pkg::CH_Z1: s_next.sw = tadc_pkg::SW_PRESS;
                default: s_next.sw = tadc_pkg::SW_OFF;
            endcase
        end
        s_next.chan_out = s_next.ch;
        s_next.sds_out = s_next.ctrl1[tadc_pkg::SDS_BIT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.ctrl1 <= tadc_pkg::CTRL_RESET;
            s_reg.ctrl2 <= tadc_pkg::CTRL_RESET;
            s_reg.st <= ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from flip-flops; pready tied high (zero wait)
    assign prdata = s_reg.prdata;
    assign pready = 1'b1;
    assign pslverr = s_reg.pslverr;
    assign conv_start = s_reg.conv_start;
    assign input_channel_code = s_reg.chan_out;
    assign single_diff_select = s_reg.sds_out;
    assign plate_sw = s_reg.sw;
endmodule

// ### tadc_ctrl_tb.sv
// Self-checking bench for the conversion-control block.
// Drives APB and touch; the core model answers each conversion.
module tadc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic touched = 1'h0, pready, pslverr, conv_done, conv_start, sds, last_err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] chan, sw;
    logic [7:0] lat = 8'h00;
    logic [8:0] ev_q[$];
    int t_q[$];
    int n_errors = 0, n_tests = 0, cyc = 0, gap, ex;
    // 40 MHz clock
    always #12.5 pclk = ~pclk;
    // Log every conversion start with its method, plates and channel
    always @(posedge pclk) begin
        cyc++;
        if (conv_start === 1'h1) begin
            ev_q.push_back({sds, sw, chan});
            t_q.push_back(cyc);
        end
    end
    tadc_ctrl tadc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .touched(touched), .conv_done(conv_done), .conv_start(conv_start),
        .input_channel_code(chan), .single_diff_select(sds), .plate_sw(sw));
    tadc_core_model tadc_core_model_i (.pclk(pclk), .presetn(presetn),
        .conv_start(conv_start), .lat(lat), .conv_done(conv_done));
    task automatic close_out();
        $display("mismatches %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; read data and error are taken at the edge that sees pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'h1) break;
        end
        if (k == 16) begin
            n_errors++;
            close_out();
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wait_ev(input int n, input int lim);
        for (int k = 0; k < lim && ev_q.size() < n; k++) @(posedge pclk);
        if (ev_q.size() < n) begin
            n_errors++;
            close_out();
        end
    endtask
    task automatic chk_ev(input logic d, input logic [3:0] c);
        logic [8:0] ev;
        ev = ev_q.pop_front();
        chk("channel", {28'h0, c}, {28'h0, ev[3:0]});
        chk("method", {31'h0, d}, {31'h0, ev[8]});
        ex = c == 4'h0 ? 3 : c == 4'h1 ? 12 : (c == 4'h2 || c == 4'hA) ? 6 : 0;
        chk("plates", ex, {28'h0, ev[7:4]});
    endtask
    task automatic t_reset();
        apb(1'h0, 12'h000, 32'h0);
        chk("ctrl1", 32'h0, rd);
        apb(1'h0, 12'h004, 32'h0);
        chk("ctrl2", 32'h0, rd);
        apb(1'h1, 12'h040, 32'hFFF);
        chk("slverr", 32'h1, {31'h0, last_err});
    endtask
    // Codes 0 to 11, odd codes with the method bit set and a slow core, even codes with it clear and a prompt core; code 11 is refused
    task automatic t_single();
        for (int c = 0; c < 12; c++) begin
            lat <= c[0] ? 8'h1E : 8'h00;
            apb(1'h1, 12'h000, {20'h0, c[0], c[3:0], 5'h00, 2'h1});
            if (c < 11) wait_ev(1, 200);
            if (c < 11) chk_ev(c[0], c[3:0]);
            repeat (50) @(posedge pclk);
            chk("extra", 32'h0, ev_q.size());
            apb(1'h0, 12'h000, 32'h0);
            chk("mode", 32'h0, {30'h0, rd[1:0]});
        end
    endtask
    task automatic t_seq();
        apb(1'h1, 12'h008, 32'h843);
        apb(1'h1, 12'h000, 32'h0);
        repeat (100) @(posedge pclk);
        chk("idle", 32'h0, ev_q.size());
        apb(1'h1, 12'h000, {20'h0, 1'h1, 4'h0, 5'h00, 2'h2});
        wait_ev(3, 500);
        chk_ev(1'h1, 4'h0);
        chk_ev(1'h1, 4'h5);
        chk_ev(1'h1, 4'hA);
        repeat (100) @(posedge pclk);
        chk("extra", 32'h0, ev_q.size());
    endtask
    // Interval 01 in single mode, 10 in slave sequence mode
    task automatic t_repeat();
        for (int m = 1; m < 3; m++) begin
            ev_q.delete();
            t_q.delete();
            apb(1'h1, 12'h004, m);
            apb(1'h1, 12'h008, 32'h100);
            apb(1'h1, 12'h000, {20'h0, 1'h0, 4'h3, 5'h00, m[1:0]});
            wait_ev(2, 45000);
            gap = t_q[1] - t_q[0];
            ex = m * 1024 * tadc_pkg::CONV_DIV;
            chk("period", 32'h1, {31'h0, gap > ex - 60 && gap < ex + 60});
            chk_ev(1'h0, 4'h3);
            apb(1'h1, 12'h000, 32'h0);
        end
        apb(1'h1, 12'h004, 32'h0);
    endtask
    task automatic t_master();
        ev_q.delete();
        apb(1'h1, 12'h00C, 32'h600);
        apb(1'h1, 12'h000, {20'h0, 1'h0, 4'h0, 5'h00, 2'h3});
        repeat (100) @(posedge pclk);
        chk("untouched", 32'h0, ev_q.size());
        for (int t = 0; t < 2; t++) begin
            touched <= 1'h1;
            wait_ev(2, 500);
            chk_ev(1'h0, 4'h1);
            chk_ev(1'h0, 4'h2);
            repeat (200) @(posedge pclk);
            chk("held", 32'h0, ev_q.size());
            touched <= 1'h0;
            repeat (20) @(posedge pclk);
        end
        apb(1'h1, 12'h000, 32'h0);
    endtask
    // Hang guard
    initial begin
        repeat (95000) @(posedge pclk);
        n_errors++;
        close_out();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_reset();
        t_single();
        t_seq();
        t_repeat();
        t_master();
        close_out();
    end
endmodule
bind tadc_ctrl tadc_chk tadc_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .conv_start(conv_start), .conv_done(conv_done), .input_channel_code(input_channel_code),
    .single_diff_select(single_diff_select), .plate_sw(plate_sw));

// ### tadc_pkg.sv
// Package for the touch ADC conversion-control block.
// Assumes a single 40 MHz pclk domain; used by tadc_ctrl and its bench.
package tadc_pkg;
    // Register byte addresses on APB
    localparam logic [11:0] ADDR_CTRL1 = 12'h000;
    localparam logic [11:0] ADDR_CTRL2 = 12'h004;
    localparam logic [11:0] ADDR_SEQ0 = 12'h008;
    localparam logic [11:0] ADDR_SEQ1 = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    localparam logic [11:0] ADDR_CONV = 12'h014;
    // Reset values
    localparam logic [11:0] CTRL_RESET = 12'h000;
    // Main control word field positions
    localparam int SDS_BIT = 11;
    localparam int CH_LSB = 7;
    localparam int RB_LSB = 2;
    // Mode codes
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_SLAVE_SEQ = 2'h2;
    localparam logic [1:0] MODE_MASTER = 2'h3;
    // Channel codes
    localparam logic [3:0] CH_YPOS = 4'h0;
    localparam logic [3:0] CH_XPOS = 4'h1;
    localparam logic [3:0] CH_Z2 = 4'h2;
    localparam logic [3:0] CH_Z1 = 4'hA;
    localparam logic [3:0] CH_LAST = 4'hA;
    // Repeat intervals, in conversion clocks
    localparam int REP_1 = 1024;
    localparam int REP_2 = 2048;
    localparam int REP_3 = 16384;
    // Conversion clock is pclk / CONV_DIV
    localparam int CONV_DIV = 20;
    // Plate switch bit positions: {xp, xm, yp, ym}
    localparam logic [3:0] SW_OFF = 4'h0;
    localparam logic [3:0] SW_Y_ON = 4'h3;
    localparam logic [3:0] SW_X_ON = 4'hC;
    localparam logic [3:0] SW_PRESS = 4'h6;
endpackage
